// File: meas_mem_pkg.sv
package meas_mem_pkg;

   // Store capacity and index widths
   localparam int unsigned MEM_DEPTH = 400;
   localparam int unsigned IDX_W = 9;
   localparam int unsigned DATA_W = 32;
   localparam logic [IDX_W-1:0] MEM_FULL = MEM_DEPTH[IDX_W-1:0];

   // Reset values
   localparam logic [IDX_W-1:0] COUNT_RST = 9'h000;
   localparam logic [IDX_W-1:0] IDX_RST = 9'h000;
   localparam logic [IDX_W-1:0] SEQ_BASE = 9'h001;

   // Lamp blink timing
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned BLINK_MS = 100;
   localparam int unsigned BLINK_CYCLES = BLINK_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned BLINK_W = 25;

   // Read-out engine states
   typedef enum logic [1:0] {
      RD_IDLE,
      RD_SEND,
      RD_WAIT_N
   } rd_state_type;

   // One line of read-out: a record or the END line
   typedef struct packed {
      logic is_end;
      logic [IDX_W-1:0] seq;
      logic [DATA_W-1:0] res;
      logic [DATA_W-1:0] volt;
   } rec_type;

endpackage

// File: meas_record_store.sv
`timescale 1ns/1ps
module meas_record_store #(
   parameter int unsigned BLINK_CYCLES = meas_mem_pkg::BLINK_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic cmd_mem_on,
   input wire logic cmd_mem_off,
   input wire logic cmd_mem_clear,
   input wire logic cmd_read_all,
   input wire logic cmd_read_step,
   input wire logic host_next,
   input wire logic range_change,
   input wire logic comp_change,
   input wire logic menu_reset,
   input wire logic reset_cmd,
   input wire logic trigger_input_pin_source_ext,
   input wire logic key_trigger_input_pin,
   input wire logic trigger_input_pin,
   input wire logic bus_trigger_input_pin,
   input wire logic meas_valid,
   input wire logic [meas_mem_pkg::DATA_W-1:0] meas_res,
   input wire logic [meas_mem_pkg::DATA_W-1:0] meas_volt,
   input wire logic out_ready,
   output logic out_valid,
   output logic out_end,
   output logic [meas_mem_pkg::IDX_W-1:0] out_seq,
   output logic [meas_mem_pkg::DATA_W-1:0] out_res,
   output logic [meas_mem_pkg::DATA_W-1:0] out_volt,
   output logic mem_lamp,
   output logic auto_range_allow,
   output logic meas_start,
   output logic [meas_mem_pkg::IDX_W-1:0] record_count
);

   typedef struct packed {
      logic enabled;
      logic pending;
      logic [meas_mem_pkg::IDX_W-1:0] count;
      logic [meas_mem_pkg::MEM_DEPTH-1:0][meas_mem_pkg::DATA_W-1:0] res_mem;
      logic [meas_mem_pkg::MEM_DEPTH-1:0][meas_mem_pkg::DATA_W-1:0] volt_mem;
      meas_mem_pkg::rd_state_type rd_state;
      logic step_mode;
      logic [meas_mem_pkg::IDX_W-1:0] rd_idx;
      logic head_v;
      meas_mem_pkg::rec_type head;
      logic spare_v;
      meas_mem_pkg::rec_type spare;
      logic [meas_mem_pkg::BLINK_W-1:0] blink_cnt;
      logic lamp;
      logic auto_range_allow;
      logic meas_start;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   // Event decode shared by logic and checks
   logic any_trigger_input_pin;
   logic clr_any;
   logic store_go;
   logic send_go;
   logic pop;
   meas_mem_pkg::rec_type line_in;

   assign any_trigger_input_pin = key_trigger_input_pin | trigger_input_pin | bus_trigger_input_pin;
   // Every clearing event, enable rise included
   assign clr_any = cmd_mem_clear | range_change | comp_change | menu_reset |
      reset_cmd | (cmd_mem_on & ~s_r.enabled);
   assign store_go = s_r.enabled & s_r.pending & meas_valid & ~clr_any &
      ~cmd_mem_off;
   // Read engine may only push while the spare slot is free
   assign send_go = (s_r.rd_state == meas_mem_pkg::RD_SEND) & ~s_r.spare_v &
      ~clr_any;
   assign pop = s_r.head_v & out_ready;

   // Next line for the output buffer
   always_comb begin
      line_in.is_end = (s_r.rd_idx == s_r.count);
      line_in.seq = s_r.rd_idx + meas_mem_pkg::SEQ_BASE;
      line_in.res = '0;
      line_in.volt = '0;
      if (!line_in.is_end) begin
         line_in.res = s_r.res_mem[s_r.rd_idx];
         line_in.volt = s_r.volt_mem[s_r.rd_idx];
      end
   end

   // Next-state logic for the whole block
   always_comb begin
      s_nxt = s_r;
      s_nxt.meas_start = 1'b0;

      // Enable only from host command, off stops storing
      if (cmd_mem_off) begin
         s_nxt.enabled = 1'b0;
         s_nxt.pending = 1'b0;
      end else if (cmd_mem_on) begin
         s_nxt.enabled = 1'b1;
      end

      // One measurement per external trigger
      if (any_trigger_input_pin && trigger_input_pin_source_ext) begin
         s_nxt.meas_start = 1'b1;
      end

      // Arm capture of the next completed measurement
      if (s_r.enabled && !cmd_mem_off && any_trigger_input_pin && !s_r.pending) begin
         s_nxt.pending = 1'b1;
      end

      // Append in trigger order, nothing once full
      if (store_go) begin
         s_nxt.pending = 1'b0;
         if (s_r.count != meas_mem_pkg::MEM_FULL) begin
            s_nxt.res_mem[s_r.count] = meas_res;
            s_nxt.volt_mem[s_r.count] = meas_volt;
            s_nxt.count = s_r.count + 9'h001;
            s_nxt.blink_cnt = BLINK_CYCLES[meas_mem_pkg::BLINK_W-1:0];
         end
      end else if (s_r.blink_cnt != '0) begin
         s_nxt.blink_cnt = s_r.blink_cnt - 25'h0000001;
      end

      // Clear empties store and aborts a read-out
      if (clr_any) begin
         s_nxt.count = meas_mem_pkg::COUNT_RST;
         s_nxt.pending = 1'b0;
         s_nxt.rd_state = meas_mem_pkg::RD_IDLE;
         s_nxt.rd_idx = meas_mem_pkg::IDX_RST;
      end else begin
         case (s_r.rd_state)
            meas_mem_pkg::RD_IDLE: begin
               if (cmd_read_all || cmd_read_step) begin
                  s_nxt.rd_state = meas_mem_pkg::RD_SEND;
                  s_nxt.step_mode = cmd_read_step;
                  s_nxt.rd_idx = meas_mem_pkg::IDX_RST;
               end
            end
            meas_mem_pkg::RD_SEND: begin
               if (send_go && line_in.is_end) begin
                  s_nxt.rd_state = meas_mem_pkg::RD_IDLE;
               end else if (send_go) begin
                  s_nxt.rd_idx = s_r.rd_idx + 9'h001;
                  if (s_r.step_mode) begin
                     s_nxt.rd_state = meas_mem_pkg::RD_WAIT_N;
                  end
               end
            end
            meas_mem_pkg::RD_WAIT_N: begin
               if (host_next) begin
                  s_nxt.rd_state = meas_mem_pkg::RD_SEND;
               end
            end
            default: begin
               s_nxt.rd_state = meas_mem_pkg::RD_IDLE;
            end
         endcase
      end

      // Two-entry buffer: head feeds the port, spare absorbs a stall
      if (pop) begin
         if (s_r.spare_v) begin
            s_nxt.head = s_r.spare;
            s_nxt.spare_v = 1'b0;
         end else begin
            s_nxt.head_v = send_go;
            s_nxt.head = line_in;
         end
         if (s_r.spare_v && send_go) begin
            s_nxt.spare = line_in;
            s_nxt.spare_v = 1'b1;
         end
      end else if (send_go) begin
         if (!s_r.head_v) begin
            s_nxt.head = line_in;
            s_nxt.head_v = 1'b1;
         end else begin
            s_nxt.spare = line_in;
            s_nxt.spare_v = 1'b1;
         end
      end

      // Lamp lit while enabled, dark during a blink
      s_nxt.lamp = s_nxt.enabled && (s_nxt.blink_cnt == '0);
      s_nxt.auto_range_allow = !s_nxt.enabled;
   end

   // State register, frozen while ce is low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
         s_r.auto_range_allow <= 1'b1;
         s_r.rd_state <= meas_mem_pkg::RD_IDLE;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state flops
   assign out_valid = s_r.head_v;
   assign out_end = s_r.head.is_end;
   assign out_seq = s_r.head.seq;
   assign out_res = s_r.head.res;
   assign out_volt = s_r.head.volt;
   assign mem_lamp = s_r.lamp;
   assign auto_range_allow = s_r.auto_range_allow;
   assign meas_start = s_r.meas_start;
   assign record_count = s_r.count;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   // Store and read-out event sequences
   sequence seq_store_slot;
      ce && store_go && (s_r.count != meas_mem_pkg::MEM_FULL);
   endsequence

   sequence seq_step_sent;
      ce && send_go && s_r.step_mode && !line_in.is_end;
   endsequence

   a_append_order: assert property (seq_store_slot |=>
      s_r.count == $past(s_r.count) + 9'h001 &&
      s_r.res_mem[$past(s_r.count)] == $past(meas_res) && !s_r.lamp)
      else $error("record not appended at end");

   a_full_no_add: assert property (
      (ce && s_r.count == meas_mem_pkg::MEM_FULL && !clr_any) |=>
      s_r.count == meas_mem_pkg::MEM_FULL)
      else $error("full store changed");

   a_count_limit: assert property (
      s_r.count <= meas_mem_pkg::MEM_FULL)
      else $error("count above capacity");

   a_clear_empties: assert property ((ce && clr_any) |=>
      s_r.count == meas_mem_pkg::COUNT_RST &&
      s_r.rd_state == meas_mem_pkg::RD_IDLE)
      else $error("clear did not empty store");

   a_disable_lamp: assert property ((ce && cmd_mem_off) |=>
      !s_r.lamp && !s_r.enabled ##1
      (!s_r.enabled || $past(ce && cmd_mem_on)))
      else $error("disable left lamp or store on");

   a_auto_range_lock: assert property (s_r.enabled |->
      !auto_range_allow) else $error("auto range allowed while enabled");

   // External trigger asks for exactly one measurement
   a_ext_meas_req: assert property (
      (ce && any_trigger_input_pin && trigger_input_pin_source_ext) |=> meas_start)
      else $error("external trigger without measurement");

   a_no_stray_meas: assert property (
      (ce && !(any_trigger_input_pin && trigger_input_pin_source_ext)) |=> !meas_start)
      else $error("measurement request without trigger");

   a_step_waits: assert property (seq_step_sent |=>
      (s_r.rd_state == meas_mem_pkg::RD_WAIT_N) ##1
      ((s_r.rd_state != meas_mem_pkg::RD_SEND) ||
      $past(host_next) || $past(clr_any) || !$past(ce)))
      else $error("step read did not wait for N");

   a_end_last: assert property ((ce && send_go && line_in.is_end) |=>
      s_r.rd_state == meas_mem_pkg::RD_IDLE && (s_r.head_v || s_r.spare_v))
      else $error("END line not queued after last record");

   a_seq_number: assert property (
      (ce && send_go && !line_in.is_end) |->
      line_in.seq != '0 && line_in.seq <= s_r.count)
      else $error("bad sequence number");

   a_one_per_trigger_input_pin: assert property ((ce && store_go) |=> !s_r.pending)
      else $error("capture armed twice for one trigger");

   // Stall, arming, disable and bulk-read checks
   sequence seq_line_stalled;
      ce && s_r.head_v && !out_ready;
   endsequence

   a_buf_hold: assert property (seq_line_stalled |=>
      out_valid && $stable(out_seq) && $stable(out_end) &&
      $stable(out_res))
      else $error("stalled line lost or changed");

   a_off_no_store: assert property (
      (ce && !s_r.enabled && !clr_any) |=> $stable(s_r.count))
      else $error("record stored while disabled");

   a_trigger_input_pin_arms: assert property (
      (ce && s_r.enabled && any_trigger_input_pin && !s_r.pending && !cmd_mem_off &&
      !clr_any) |=> s_r.pending)
      else $error("trigger did not arm a capture");

   a_bulk_no_wait: assert property (
      (ce && send_go && !s_r.step_mode) |=>
      s_r.rd_state != meas_mem_pkg::RD_WAIT_N)
      else $error("bulk read stopped to wait");

endmodule

// File: line_receiver.sv
`timescale 1ns/1ps
// Host side of the read-out stream: takes lines, may stall
module line_receiver (
   input wire logic clk,
   input wire logic nrst,
   input wire logic stall,
   input wire logic out_valid,
   input wire logic out_end,
   input wire logic [meas_mem_pkg::IDX_W-1:0] out_seq,
   input wire logic [meas_mem_pkg::DATA_W-1:0] out_res,
   input wire logic [meas_mem_pkg::DATA_W-1:0] out_volt,
   output logic out_ready
);
   meas_mem_pkg::rec_type lines[$];
   logic tog_r;
   // Ready always, or every other cycle while stalling
   assign out_ready = !stall || tog_r;
   // Toggle the stall phase and keep every line taken
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tog_r <= 1'b0;
      end else begin
         tog_r <= !tog_r;
         if (out_valid && out_ready) begin
            lines.push_back({out_end, out_seq, out_res, out_volt});
         end
      end
   end
endmodule

// File: measurement_record_memory_tb_top.sv
`timescale 1ns/1ps
module measurement_record_memory_tb_top;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ext_src = 1'b1;
   logic stall = 1'b0;
   logic en = 1'b0;
   logic [13:0] cmd = 14'h0000;
   logic [31:0] meas_res = 32'h00000000;
   logic [31:0] meas_volt = 32'h00000000;
   logic out_ready, out_valid, out_end, mem_lamp, auto_range_allow;
   logic meas_start;
   logic [8:0] out_seq, record_count;
   logic [31:0] out_res, out_volt;
   int fails = 0;
   int n_compared = 0;
   int n = 0;
   int clr[5] = '{2, 6, 7, 8, 9};
   // 200 MHz clock
   always #2.5 clk = !clk;
   meas_record_store #(.BLINK_CYCLES(4)) dut (
      .clk(clk), .nrst(nrst), .ce(1'b1), .cmd_mem_on(cmd[0]),
      .cmd_mem_off(cmd[1]), .cmd_mem_clear(cmd[2]), .cmd_read_all(cmd[3]),
      .cmd_read_step(cmd[4]), .host_next(cmd[5]), .range_change(cmd[6]),
      .comp_change(cmd[7]), .menu_reset(cmd[8]), .reset_cmd(cmd[9]),
      .trigger_input_pin_source_ext(ext_src), .key_trigger_input_pin(cmd[10]),
      .trigger_input_pin(cmd[11]), .bus_trigger_input_pin(cmd[12]),
      .meas_valid(cmd[13]), .meas_res(meas_res), .meas_volt(meas_volt),
      .out_ready(out_ready), .out_valid(out_valid), .out_end(out_end),
      .out_seq(out_seq), .out_res(out_res), .out_volt(out_volt),
      .mem_lamp(mem_lamp), .auto_range_allow(auto_range_allow),
      .meas_start(meas_start), .record_count(record_count));
   line_receiver rx (
      .clk(clk), .nrst(nrst), .stall(stall), .out_valid(out_valid),
      .out_end(out_end), .out_seq(out_seq), .out_res(out_res),
      .out_volt(out_volt), .out_ready(out_ready));
   task automatic tally_and_finish();
      if (fails == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle pulse on a command bit, then let outputs settle
   task automatic pulse(int b);
      @(posedge clk);
      cmd[b] <= 1'b1;
      @(posedge clk);
      cmd[b] <= 1'b0;
      #1;
   endtask
   function automatic logic [31:0] res_of(int i);
      return {16'hA5A5, i[15:0]};
   endfunction
   // Trigger from one source, then one finished measurement
   task automatic store(int src);
      pulse(src);
      chk("meas_start", ext_src, meas_start);
      @(posedge clk);
      meas_res <= res_of(n + 1);
      meas_volt <= ~res_of(n + 1);
      pulse(13);
      if (en && n < 400) begin
         n++;
         chk("mem_lamp", 0, mem_lamp);
      end
      chk("record_count", n, record_count);
   endtask
   // Bulk or stepwise read, every line compared
   task automatic read_back(bit step);
      meas_mem_pkg::rec_type l;
      rx.lines.delete();
      pulse(step ? 4 : 3);
      for (int i = 1; i <= n; i++) begin
         repeat (20) @(posedge clk);
         #1;
         if (step) begin
            chk("lines waiting", i, rx.lines.size());
            pulse(5);
         end
      end
      repeat (20) @(posedge clk);
      #1;
      chk("lines", n + 1, rx.lines.size());
      if (rx.lines.size() == n + 1) begin
         for (int i = 1; i <= n + 1; i++) begin
            l = rx.lines[i-1];
            chk("out_end", i > n, l.is_end);
            if (i <= n) begin
               chk("out_seq", i, l.seq);
               chk("out_res", res_of(i), l.res);
               chk("out_volt", ~res_of(i), l.volt);
            end
         end
      end
   endtask
   // Scenario: triggers while off store nothing; host enable lights lamp
   task automatic scen_enable();
      chk("record_count", 0, record_count);
      chk("auto_range", 1, auto_range_allow);
      store(10);
      pulse(0);
      en = 1'b1;
      chk("mem_lamp", 1, mem_lamp);
      chk("auto_range", 0, auto_range_allow);
   endtask
   // Scenario: every source appends; bulk read under stall, then step read
   task automatic scen_append_read();
      store(10);
      store(11);
      store(12);
      @(posedge clk);
      ext_src <= 1'b0;
      stall <= 1'b1;
      store(10);
      read_back(0);
      stall <= 1'b0;
      chk("mem_lamp", 1, mem_lamp);
      store(12);
      read_back(1);
   endtask
   // Scenario: each clearing event except the enable rise empties the store
   task automatic scen_clears();
      foreach (clr[k]) begin
         store(11);
         pulse(clr[k]);
         n = 0;
         chk("record_count", 0, record_count);
      end
   endtask
   // Scenario: fill past capacity, disable, re-enable clears
   task automatic scen_full_off();
      @(posedge clk);
      ext_src <= 1'b1;
      repeat (401) store(11);
      pulse(1);
      en = 1'b0;
      chk("mem_lamp", 0, mem_lamp);
      chk("auto_range", 1, auto_range_allow);
      store(12);
      pulse(0);
      en = 1'b1;
      n = 0;
      chk("record_count", 0, record_count);
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      #1;
      scen_enable();
      scen_append_read();
      scen_clears();
      scen_full_off();
      tally_and_finish();
   end
   // Watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule
